// file: common/lane_pll_pkg.sv
// Types shared by the lane and PLL control bank.
package lane_pll_pkg;

  typedef enum logic [1:0] {
    LOOP_OFF       = 2'h0,
    LOOP_PAD       = 2'h1,
    LOOP_DIG_QUIET = 2'h2,
    LOOP_DIG_DRIVE = 2'h3
  } loop_mode_t;

  typedef struct packed {
    logic [1:0] bandwidth;
    logic       bandwidthReserved;
    loop_mode_t loopPath;
    logic       padLoop;
    logic       digitalLoop;
    logic       cmlDriverOn;
    logic       pllEnable;
    logic [3:0] multCode;
    logic [7:0] multTimesTwo;
    logic       multReserved;
  } pll_ctrl_t;

endpackage : lane_pll_pkg

// file: common/lane_pll_regs.svh
// Register offsets, field positions and reset values of the lane and PLL control bank.
`ifndef LANE_PLL_REGS_SVH
`define LANE_PLL_REGS_SVH

`define LP_ADDR_W        5
`define LP_DATA_W        16
`define LP_LANES         4

`define LP_ADDR_CTRL     5'h06
`define LP_ADDR_SETA     5'h07
`define LP_ADDR_SETB     5'h08
`define LP_ADDR_LOOPEXT  5'h1E

`define LP_CTRL_RESET    16'hF115
`define LP_SETA_RESET    16'hDC04
`define LP_SETB_RESET    16'h0001
`define LP_LOOPEXT_RESET 16'h0000

`define LP_MASK_HI       15
`define LP_MASK_LO       12
`define LP_RSVA_HI       11
`define LP_RSVA_LO       10
`define LP_BW_HI         9
`define LP_BW_LO         8
`define LP_LOOP_BIT      7
`define LP_RSVB_HI       6
`define LP_RSVB_LO       5
`define LP_PLLON_BIT     4
`define LP_MULT_HI       3
`define LP_MULT_LO       0
`define LP_LOOPEXT_BIT   0

`endif

// file: core/lane_settings_bank.sv
// Storage of both settings words for one low-speed lane.
`timescale 1ns/1ps
`include "lane_pll_regs.svh"

module lane_settings_bank #(
  parameter logic [`LP_DATA_W-1:0] RESET_A = `LP_SETA_RESET,
  parameter logic [`LP_DATA_W-1:0] RESET_B = `LP_SETB_RESET
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Gated write strobes and data.
  input  wire logic                  writeA,
  input  wire logic                  writeB,
  input  wire logic [`LP_DATA_W-1:0] wdata,
  // Stored settings.
  output logic      [`LP_DATA_W-1:0] settingsA,
  output logic      [`LP_DATA_W-1:0] settingsB
);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settingsA <= RESET_A;
    end else if (writeA) begin
      settingsA <= wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settingsB <= RESET_B;
    end else if (writeB) begin
      settingsB <= wdata;
    end
  end

endmodule : lane_settings_bank

// file: core/low_side_lane_pll_control.sv
// Low-speed-side lane selection and PLL control register with per-lane settings.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "lane_pll_regs.svh"

module low_side_lane_pll_control
  import lane_pll_pkg::*;
#(
  parameter int LANES = `LP_LANES
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Register port.
  input  wire logic [`LP_ADDR_W-1:0]   addr,
  input  wire logic [`LP_DATA_W-1:0]   wdata,
  input  wire logic                    wstrobe,
  input  wire logic                    rstrobe,
  output logic      [`LP_DATA_W-1:0]   rdata,
  // Channel controls from outside the bank.
  input  wire logic                    channelPowerdown_n,
  input  wire logic                    softReset,
  input  wire logic                    farLoopbackOn,
  // Decoded controls.
  output pll_ctrl_t                    pllCtrl,
  output logic [LANES-1:0][`LP_DATA_W-1:0] laneSettingsA,
  output logic [LANES-1:0][`LP_DATA_W-1:0] laneSettingsB
);

  logic [`LP_DATA_W-1:0] ctrl_q;
  logic                  loopExt_q;
  logic [`LP_DATA_W-1:0] rdata_q;
  logic [`LP_DATA_W-1:0] rdata_d;
  logic [2:0]            pdSync_q;
  logic                  pdStable_q;
  logic [LANES-1:0]      laneMask;
  logic                  maskOneHot;
  logic                  writeSetA;
  logic                  writeSetB;
  logic [`LP_DATA_W-1:0] selA;
  logic [`LP_DATA_W-1:0] selB;
  loop_mode_t            loopPath;
  logic                  loopLive;

  assign laneMask  = ctrl_q[`LP_MASK_HI:`LP_MASK_LO];
  assign writeSetA = wstrobe && (addr == `LP_ADDR_SETA);
  assign writeSetB = wstrobe && (addr == `LP_ADDR_SETB);

  //////////////////////////////////////////////////////////////////////////////
  // Control register; every field, reserved pairs included, is stored as written.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `LP_CTRL_RESET;
    end else if (wstrobe && (addr == `LP_ADDR_CTRL)) begin
      ctrl_q <= wdata;
    end
  end

  // The loopback code has two bits but only one sits in the control word.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loopExt_q <= 1'b0;
    end else if (wstrobe && (addr == `LP_ADDR_LOOPEXT)) begin
      loopExt_q <= wdata[`LP_LOOPEXT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-lane settings; one write reaches all enabled lanes in the same cycle.

  for (genvar n = 0; n < LANES; n++) begin : g_lane
    lane_settings_bank #(
      .RESET_A (`LP_SETA_RESET),
      .RESET_B (`LP_SETB_RESET)
    ) u_bank (
      .clk       (clk),
      .reset     (reset),
      .writeA    (writeSetA && laneMask[n]),
      .writeB    (writeSetB && laneMask[n]),
      .wdata     (wdata),
      .settingsA (laneSettingsA[n]),
      .settingsB (laneSettingsB[n])
    );
  end

  assign maskOneHot = (laneMask != '0) &&
                      ((laneMask & (laneMask - LANES'(1))) == '0);

  // A mask that is not one-hot returns zero rather than a blend of lanes.
  always_comb begin
    selA = '0;
    selB = '0;
    for (int n = 0; n < LANES; n++) begin
      if (maskOneHot && laneMask[n]) begin
        selA = laneSettingsA[n];
        selB = laneSettingsB[n];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port; data stand only in the cycle after the strobe.

  always_comb begin
    rdata_d = '0;
    if (rstrobe) begin
      case (addr)
        `LP_ADDR_CTRL:    rdata_d = ctrl_q;
        `LP_ADDR_SETA:    rdata_d = selA;
        `LP_ADDR_SETB:    rdata_d = selB;
        `LP_ADDR_LOOPEXT: rdata_d = {{(`LP_DATA_W-1){1'b0}}, loopExt_q};
        default:          rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Powerdown pin filter; a change counts once the last two stages agree.

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pdSync_q <= 3'h0;
    end else begin
      pdSync_q <= {pdSync_q[1:0], channelPowerdown_n};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pdStable_q <= 1'b0;
    end else if (pdSync_q[1] == pdSync_q[2]) begin
      pdStable_q <= pdSync_q[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded PLL and loopback controls.

  assign loopPath = loop_mode_t'({ctrl_q[`LP_LOOP_BIT], loopExt_q});
  assign loopLive = farLoopbackOn && (loopPath != LOOP_OFF);

  always_comb begin
    pllCtrl                   = '0;
    pllCtrl.bandwidth         = ctrl_q[`LP_BW_HI:`LP_BW_LO];
    pllCtrl.bandwidthReserved = (ctrl_q[`LP_BW_HI] == ctrl_q[`LP_BW_LO]);
    pllCtrl.loopPath          = loopPath;
    pllCtrl.padLoop           = loopLive && (loopPath == LOOP_PAD);
    pllCtrl.digitalLoop       = loopLive && ctrl_q[`LP_LOOP_BIT];
    pllCtrl.cmlDriverOn       = !(loopLive && (loopPath == LOOP_DIG_QUIET));
    pllCtrl.pllEnable         = ctrl_q[`LP_PLLON_BIT] && pdStable_q && !softReset;
    pllCtrl.multCode          = ctrl_q[`LP_MULT_HI:`LP_MULT_LO];
    case (ctrl_q[`LP_MULT_HI:`LP_MULT_LO])
      4'h0:    pllCtrl.multTimesTwo = 8'h08;
      4'h1:    pllCtrl.multTimesTwo = 8'h0A;
      4'h2:    pllCtrl.multTimesTwo = 8'h0C;
      4'h4:    pllCtrl.multTimesTwo = 8'h10;
      4'h5:    pllCtrl.multTimesTwo = 8'h14;
      4'h6:    pllCtrl.multTimesTwo = 8'h18;
      4'h7:    pllCtrl.multTimesTwo = 8'h19;
      4'h8:    pllCtrl.multTimesTwo = 8'h1E;
      4'h9:    pllCtrl.multTimesTwo = 8'h28;
      4'hA:    pllCtrl.multTimesTwo = 8'h32;
      4'hD:    pllCtrl.multTimesTwo = 8'h64;
      4'hE:    pllCtrl.multTimesTwo = 8'h82;
      default: pllCtrl.multReserved = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_maskBlocks;
    @(posedge clk) disable iff (reset)
    (writeSetA && !laneMask[0]) |=> $stable(laneSettingsA[0]);
  endproperty
  a_maskBlocks: assert property (p_maskBlocks)
    else $error("Masked lane 0 changed on a settings write.");

  property p_maskPasses;
    @(posedge clk) disable iff (reset)
    (writeSetB && laneMask[3]) |=> (laneSettingsB[3] == $past(wdata));
  endproperty
  a_maskPasses: assert property (p_maskPasses)
    else $error("Enabled lane 3 missed a settings write.");

  property p_readLane;
    @(posedge clk) disable iff (reset)
    (rstrobe && (addr == `LP_ADDR_SETA) && (laneMask == 4'h2))
      |=> (rdata == $past(laneSettingsA[1])) ##1 (rdata == '0 || $past(rstrobe));
  endproperty
  a_readLane: assert property (p_readLane)
    else $error("Settings read did not return the selected lane.");

  property p_reserved;
    @(posedge clk) disable iff (reset)
    (wstrobe && (addr == `LP_ADDR_CTRL))
      |=> (ctrl_q[11:10] == $past(wdata[11:10])) && (ctrl_q[6:5] == $past(wdata[6:5]));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved pair not stored as written.");

  property p_bandwidth;
    @(posedge clk) disable iff (reset)
    (wstrobe && (addr == `LP_ADDR_CTRL) && (wdata[9:8] == 2'h2))
      |=> !pllCtrl.bandwidthReserved && (pllCtrl.bandwidth == 2'h2);
  endproperty
  a_bandwidth: assert property (p_bandwidth)
    else $error("Bandwidth code 10 decoded wrongly.");

  property p_loopQuiet;
    @(posedge clk) disable iff (reset)
    (farLoopbackOn && ctrl_q[7] && !loopExt_q)
      |-> pllCtrl.digitalLoop && !pllCtrl.cmlDriverOn && !pllCtrl.padLoop;
  endproperty
  a_loopQuiet: assert property (p_loopQuiet)
    else $error("Digital loopback left the driver running.");

  property p_pllForcedOff;
    @(posedge clk) disable iff (reset)
    ($fell(pdSync_q[2]) && !pdSync_q[1]) |=> !pllCtrl.pllEnable;
  endproperty
  a_pllForcedOff: assert property (p_pllForcedOff)
    else $error("PLL stayed enabled after powerdown.");

  property p_softOff;
    @(posedge clk) disable iff (reset)
    softReset |-> !pllCtrl.pllEnable;
  endproperty
  a_softOff: assert property (p_softOff)
    else $error("PLL enabled during soft reset.");

  property p_mult;
    @(posedge clk) disable iff (reset)
    (wstrobe && (addr == `LP_ADDR_CTRL) && (wdata[3:0] == 4'h7))
      |=> (pllCtrl.multTimesTwo == 8'h19) && !pllCtrl.multReserved;
  endproperty
  a_mult: assert property (p_mult)
    else $error("Multiplier 12.5x decoded wrongly.");

  property p_broadcast;
    @(posedge clk) disable iff (reset)
    (writeSetA && (laneMask == 4'hF))
      |=> (laneSettingsA[0] == laneSettingsA[3]) && (laneSettingsA[1] == laneSettingsA[2]);
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("Broadcast write left lanes unequal.");

  property p_coverPair;
    @(posedge clk) disable iff (reset)
    writeSetA && (laneMask == 4'h3);
  endproperty
  c_coverPair: cover property (p_coverPair);

  property p_coverRead;
    @(posedge clk) disable iff (reset)
    rstrobe && (addr == `LP_ADDR_SETB) && maskOneHot;
  endproperty
  c_coverRead: cover property (p_coverRead);

  property p_coverPad;
    @(posedge clk) disable iff (reset)
    pllCtrl.padLoop;
  endproperty
  c_coverPad: cover property (p_coverPad);

endmodule : low_side_lane_pll_control

// file: tb/low_side_lane_pll_control_tb.sv
// Self-checking bench for the lane and PLL control register bank.
`timescale 1ns/1ps
`include "lane_pll_regs.svh"

`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin errorCnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module low_side_lane_pll_control_tb import lane_pll_pkg::*; ;

  logic                                 clk;
  logic                                 reset;
  logic [`LP_ADDR_W-1:0]                addr;
  logic [`LP_DATA_W-1:0]                wdata;
  logic                                 wstrobe;
  logic                                 rstrobe;
  logic [`LP_DATA_W-1:0]                rdata;
  logic                                 channelPowerdown_n;
  logic                                 softReset;
  logic                                 farLoopbackOn;
  pll_ctrl_t                            pllCtrl;
  logic [`LP_LANES-1:0][`LP_DATA_W-1:0] laneSettingsA;
  logic [`LP_LANES-1:0][`LP_DATA_W-1:0] laneSettingsB;
  int                                   errorCnt;
  int                                   totalChecks;
  // Multiplier times two per code; zero marks a reserved code.
  logic [7:0] multX2 [16] = '{8'h08, 8'h0A, 8'h0C, 8'h00, 8'h10, 8'h14, 8'h18, 8'h19,
                              8'h1E, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64, 8'h82, 8'h00};

  low_side_lane_pll_control uut (
    .clk                (clk),
    .reset              (reset),
    .addr               (addr),
    .wdata              (wdata),
    .wstrobe            (wstrobe),
    .rstrobe            (rstrobe),
    .rdata              (rdata),
    .channelPowerdown_n (channelPowerdown_n),
    .softReset          (softReset),
    .farLoopbackOn      (farLoopbackOn),
    .pllCtrl            (pllCtrl),
    .laneSettingsA      (laneSettingsA),
    .laneSettingsB      (laneSettingsB)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Each task leaves a spare edge so strobes are never set and cleared in one time step.
  task automatic wr(input logic [`LP_ADDR_W-1:0] a, input logic [`LP_DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    @(posedge clk);
    wstrobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rdChk(input logic [`LP_ADDR_W-1:0] a, input logic [`LP_DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rstrobe <= 1'b1;
    @(posedge clk);
    rstrobe <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rdChk

  task automatic endTest(input string name);
    $display("test %s done, mismatches so far %0d", name, errorCnt);
  endtask : endTest

  task automatic reportAndStop();
    $display("checks %0d, mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : reportAndStop

  //////////////////////////////////////////////////////////////////////////////////////////
  // The whole sequence needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    reportAndStop();
  end

  initial begin
    errorCnt = 0;
    totalChecks = 0;
    reset = 1'b1;
    addr = '0;
    wdata = '0;
    wstrobe = 1'b0;
    rstrobe = 1'b0;
    channelPowerdown_n = 1'b1;
    softReset = 1'b0;
    farLoopbackOn = 1'b0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rdChk(`LP_ADDR_CTRL, 16'hF115);
    `CHK(pllCtrl.pllEnable, 1'b1)
    `CHK(pllCtrl.loopPath, LOOP_OFF)
    `CHK(pllCtrl.multTimesTwo, 8'h14)
    rdChk(5'h10, 16'h0000);
    endTest("reset");

    wr(`LP_ADDR_CTRL, 16'h3115);
    wr(`LP_ADDR_SETA, 16'hA5A5);
    wr(`LP_ADDR_SETB, 16'h5A5A);
    for (int i = 0; i < 4; i++) begin
      `CHK(laneSettingsA[i], (i < 2) ? 16'hA5A5 : `LP_SETA_RESET)
      `CHK(laneSettingsB[i], (i < 2) ? 16'h5A5A : `LP_SETB_RESET)
    end
    rdChk(`LP_ADDR_SETA, 16'h0000);
    wr(`LP_ADDR_CTRL, 16'h0115);
    wr(`LP_ADDR_SETA, 16'hFFFF);
    `CHK(laneSettingsA[2], `LP_SETA_RESET)
    for (int i = 0; i < 4; i++) begin
      wr(`LP_ADDR_CTRL, {4'(1 << i), 12'h115});
      wr(`LP_ADDR_SETA, 16'hC000 + 16'(i));
    end
    for (int i = 0; i < 4; i++) begin
      wr(`LP_ADDR_CTRL, {4'(1 << i), 12'h115});
      rdChk(`LP_ADDR_SETA, 16'hC000 + 16'(i));
      rdChk(`LP_ADDR_SETB, (i < 2) ? 16'h5A5A : `LP_SETB_RESET);
    end
    wr(`LP_ADDR_CTRL, 16'hF115);
    wr(`LP_ADDR_SETA, 16'h3C3C);
    for (int i = 0; i < 4; i++) begin
      `CHK(laneSettingsA[i], 16'h3C3C)
    end
    endTest("lanes");

    wr(`LP_ADDR_CTRL, 16'hFD75);
    rdChk(`LP_ADDR_CTRL, 16'hFD75);
    wr(5'h10, 16'hFFFF);
    rdChk(`LP_ADDR_CTRL, 16'hFD75);
    for (int b = 0; b < 4; b++) begin
      wr(`LP_ADDR_CTRL, 16'hF015 | 16'(b << 8));
      `CHK(pllCtrl.bandwidth, 2'(b))
      `CHK(pllCtrl.bandwidthReserved, 1'(b == 0 || b == 3))
    end
    for (int m = 0; m < 16; m++) begin
      wr(`LP_ADDR_CTRL, 16'hF110 | 16'(m));
      `CHK(pllCtrl.multCode, 4'(m))
      `CHK(pllCtrl.multReserved, 1'(multX2[m] == 8'h00))
      if (multX2[m] != 8'h00) begin
        `CHK(pllCtrl.multTimesTwo, multX2[m])
      end
    end
    endTest("fields");

    // Test enables live in another register, and no partner lane is driven, so it stays idle.
    @(posedge clk);
    farLoopbackOn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`LP_ADDR_CTRL, 16'hF115 | 16'((c >> 1) << 7));
      wr(`LP_ADDR_LOOPEXT, 16'(c & 1));
      `CHK(pllCtrl.loopPath, loop_mode_t'(c))
      `CHK(pllCtrl.padLoop, 1'(c == 1))
      `CHK(pllCtrl.digitalLoop, 1'(c >= 2))
      `CHK(pllCtrl.cmlDriverOn, 1'(c != 2))
    end
    wr(`LP_ADDR_CTRL, 16'hF195);
    wr(`LP_ADDR_LOOPEXT, 16'h0000);
    @(posedge clk);
    farLoopbackOn <= 1'b0;
    #1;
    `CHK(pllCtrl.digitalLoop, 1'b0)
    `CHK(pllCtrl.cmlDriverOn, 1'b1)
    endTest("loopback");

    wr(`LP_ADDR_CTRL, 16'hF115);
    // Soft reset is held across one full edge so the a_softOff assertion samples it.
    @(posedge clk);
    softReset <= 1'b1;
    #1;
    `CHK(pllCtrl.pllEnable, 1'b0)
    @(posedge clk);
    softReset <= 1'b0;
    channelPowerdown_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK(pllCtrl.pllEnable, 1'b0)
    @(posedge clk);
    channelPowerdown_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK(pllCtrl.pllEnable, 1'b1)
    wr(`LP_ADDR_CTRL, 16'hF105);
    `CHK(pllCtrl.pllEnable, 1'b0)
    endTest("pll");
    reportAndStop();
  end

endmodule : low_side_lane_pll_control_tb
